// File: design/dmpwm_pkg.sv
/*
  package for the dual mode pwm channel: control register layout,
  reset values, offsets and mode constants.
  assumes a single 200 MHz system clock and an axi4-lite register port.
*/
package dmpwm_pkg;
  localparam int DMPWM_AW = 4;
  localparam logic [DMPWM_AW-1:0] DMPWM_CTRL_OFS   = 4'h0;
  localparam logic [DMPWM_AW-1:0] DMPWM_STATUS_OFS = 4'h4;
  localparam logic [31:0] DMPWM_CTRL_RESET = 32'h0000_0000;
  localparam int BIT_EN       = 0;
  localparam int BIT_POL      = 1;
  localparam int BIT_FMT      = 2;
  localparam int BIT_SAMPLE   = 3;
  localparam int BIT_MODE     = 4;
  localparam int POS_PERIOD   = 5;
  localparam int POS_DUTY     = 9;
  localparam int BIT_GATE     = 19;
  localparam int BIT_LOAD     = 20;
  localparam int POS_CLKSEL   = 21;
  localparam logic [31:0] DMPWM_CTRL_MASK = 32'h007F_FFFF;
  localparam logic [3:0]  DMPWM_PERIOD_MAX = 4'h8;
  localparam logic [3:0]  DMPWM_PERIOD_MID = 4'h4;
  localparam logic [14:0] DMPWM_TOP_BASE  = 15'h003F;
  localparam logic [14:0] DMPWM_TOP_OTHER = 15'h03FF;
  localparam logic [14:0] DMPWM_MAX_DITH  = 15'h03FF;
  localparam logic [1:0]  AXI_OKAY   = 2'b00;
  localparam logic [1:0]  AXI_SLVERR = 2'b10;
  localparam int DMPWM_BASE_KHZ = 26000;
  localparam int DMPWM_CLK_KHZ  = 200000;
  // cycles of aclk per tick of the fastest selectable base rate, rounded down
  localparam int DMPWM_DIV0 = DMPWM_CLK_KHZ / DMPWM_BASE_KHZ;
endpackage

// File: design/dmpwm_tick.sv
/*
  tick generator: makes one-cycle enables at the selected base rate.
  assumes aclk is faster than the fastest base rate.
*/
`timescale 1ns/1ps
module dmpwm_tick #(
  parameter int DIV = dmpwm_pkg::DMPWM_DIV0
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);
  import dmpwm_pkg::*;
  typedef struct packed {
    logic [7:0] pre;
    logic [2:0] oct;
    logic       tick;
  } dmpwm_tick_s;
  dmpwm_tick_s st_r;
  dmpwm_tick_s st_nxt;
  logic [2:0] oct_inc;
  always_comb begin
    st_nxt = st_r;
    oct_inc = st_r.oct + 3'h1;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt = '0;
    end else if (st_r.pre == 8'(DIV - 1)) begin
      st_nxt.pre = 8'h00;
      st_nxt.oct = oct_inc;
      // [R04] rate by divide
      case (sel)
        2'd0: st_nxt.tick = 1'b1;
        2'd1: st_nxt.tick = oct_inc[0];
        2'd2: st_nxt.tick = oct_inc[1:0] == 2'b00;
        default: st_nxt.tick = oct_inc[2:0] == 3'b000;
      endcase
    end else begin
      st_nxt.pre = st_r.pre + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
  assign tick = st_r.tick;
endmodule

// File: design/dmpwm_channel.sv
/*
  dual mode pwm channel: control register on axi4-lite, timer with
  compare match and dither (mode 1), first-order accumulator (mode 2).
  assumes aclk at 200 MHz, synchronous active-low reset, and that the
  low-power entry signal comes from logic on the same clock.
  every bus output leaves a flop; the readies stay low for the first
  cycle after reset. a second, read-only word shows the live counter,
  accumulator and pin. the base tick divides aclk by a whole number, so
  the fastest rate only approximates the nominal one.
*/
`timescale 1ns/1ps
// Overview of operation
// [R01] dither sum on top, extra cycle
// [R02] set on masked zero, clear at compare
// [R03] zero compare still emits dither pulses
// [R04] two-bit field picks channel clock
// [R05] pulse rate base over 64*2^period
// [R06] four base rates 26 down to 3.25
// [R07] duty equals compare over top+1
// [R08] configure first, drive only when enabled
// [R09] gated: load on strobe, silent otherwise
// [R10] ungated: transfer values at max count
// [R11] mode 2 eleven-bit accumulate when idle
// [R12] mode 2 output follows accumulator bit 10
// [R13] polarity bit inverts pin level
// [R14] mode 2 rate from adjusted word
// [R15] mode 2 duty word over 1024
// [R16] adjusted word flips bit 9 by format
// [R17] mode 2 loads on strobe, runs after
// [R18] mode bit selects, mode 2 ignores gating
// [R19] fixed control bit layout
// [R20] low power clears control and pwm state, bus side kept
// [R21] counter steps once per tick
// [R22] top per period code
// [R23] compare shift per period code
// [R24] reset clears fields and counters
module dmpwm_channel (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  input  wire logic                          ulp_enter,
  input  wire logic [dmpwm_pkg::DMPWM_AW-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [dmpwm_pkg::DMPWM_AW-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               pwm_out
);
  import dmpwm_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic        aw_got;
    logic        w_got;
    logic [DMPWM_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [9:0]  duty_i;
    logic [3:0]  period_i;
    logic [14:0] cnt;
    logic [3:0]  extra;
    logic        extra_pend;
    logic        level;
    logic [10:0] acc;
    logic        pin;
    logic        awready;
    logic        wready;
    logic        arready;
  } dmpwm_chan_s;

  dmpwm_chan_s st_r;
  dmpwm_chan_s st_nxt;
  logic        tick;

  // [R16] format adjust
  function automatic logic [9:0] adj_duty(input logic [9:0] d, input logic fmt);
    adj_duty = {d[9] ^ ~fmt, d[8:0]};
  endfunction

  // [R22] top per period
  function automatic logic [14:0] top_of(input logic [3:0] p);
    if (p <= DMPWM_PERIOD_MAX) begin
      top_of = 15'((16'(DMPWM_TOP_BASE) << p) | ((16'h0001 << p) - 16'h0001));
    end else begin
      top_of = DMPWM_TOP_OTHER;
    end
  endfunction

  // [R23] compare shift
  function automatic logic [14:0] cc_of(input logic [9:0] d, input logic [3:0] p);
    if (p <= DMPWM_PERIOD_MID) begin
      cc_of = 15'(d >> (DMPWM_PERIOD_MID - p));
    end else if (p <= DMPWM_PERIOD_MAX) begin
      cc_of = 15'({5'h00, d} << (p - DMPWM_PERIOD_MID));
    end else begin
      cc_of = {5'h00, d};
    end
  endfunction

  function automatic logic [3:0] shout_of(input logic [9:0] d, input logic [3:0] p);
    if (p < DMPWM_PERIOD_MID) begin
      shout_of = d[3:0] & 4'((5'h01 << (DMPWM_PERIOD_MID - p)) - 5'h01);
    end else begin
      shout_of = 4'h0;
    end
  endfunction

  // byte lanes of a write; unselected lanes keep their bits
  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    byte_mask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      byte_mask[8*i +: 8] = {8{s[i]}};
    end
  endfunction

  // status word: live accumulator, pin and counter
  function automatic logic [31:0] status_word(input logic [10:0] a, input logic p,
      input logic [14:0] c);
    status_word = {5'h00, a, p, c};
  endfunction

  logic [3:0]  f_period;
  logic [9:0]  f_duty;
  logic        f_en;
  logic        f_pol;
  logic        f_fmt;
  logic        f_sample;
  logic        f_mode;
  logic        f_gate;
  logic        f_load;
  logic [1:0]  f_clksel;

  // [R19] control layout
  assign f_en     = st_r.ctrl[BIT_EN];
  assign f_pol    = st_r.ctrl[BIT_POL];
  assign f_fmt    = st_r.ctrl[BIT_FMT];
  assign f_sample = st_r.ctrl[BIT_SAMPLE];
  assign f_mode   = st_r.ctrl[BIT_MODE];
  assign f_period = st_r.ctrl[POS_PERIOD +: 4];
  assign f_duty   = st_r.ctrl[POS_DUTY +: 10];
  assign f_gate   = st_r.ctrl[BIT_GATE];
  assign f_load   = st_r.ctrl[BIT_LOAD];
  assign f_clksel = st_r.ctrl[POS_CLKSEL +: 2];

  // [R06] base rate ticks
  dmpwm_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (f_en),
    .sel     (f_clksel),
    .tick    (tick)
  );

  logic [14:0] top_v;
  logic [14:0] max_v;
  logic [14:0] cc_v;
  logic [4:0]  dsum;
  logic        dither;
  logic        at_top;
  logic [10:0] acc_sum;
  logic        m1_out;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] wmask;
  logic        at_zero;
  logic        at_cc;
  logic        cc_zero;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;

  always_comb begin
    st_nxt = st_r;
    top_v = top_of(st_r.period_i);
    dither = !f_gate && !f_sample && st_r.period_i < DMPWM_PERIOD_MID;
    max_v = dither ? DMPWM_MAX_DITH : top_v;
    cc_v = cc_of(st_r.duty_i, st_r.period_i);
    at_top = (st_r.cnt & top_v) == top_v;
    dsum = {1'b0, shout_of(st_r.duty_i, st_r.period_i)} + {1'b0, st_r.extra};
    acc_sum = {1'b0, st_r.duty_i} + {1'b0, st_r.acc[9:0]};
    wmask = byte_mask(st_r.wstrb);
    at_zero = (st_r.cnt & top_v) == 15'h0000;
    at_cc = (st_r.cnt & top_v) == cc_v;
    cc_zero = cc_v == 15'h0000;
    aw_take = s_axi_awvalid && st_r.awready;
    w_take = s_axi_wvalid && st_r.wready;
    ar_take = s_axi_arvalid && st_r.arready;
    wr_go = 1'b0;
    wr_hit = 1'b0;
    m1_out = 1'b0;

    // axi4-lite write side; address and data in either order
    if (aw_take) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      wr_go = 1'b1;
      wr_hit = st_r.awaddr == DMPWM_CTRL_OFS;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? AXI_OKAY : AXI_SLVERR;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go && wr_hit) begin
      st_nxt.ctrl = ((st_r.ctrl & ~wmask) | (st_r.wdata & wmask)) & DMPWM_CTRL_MASK;
    end

    // read side; status shows live counter and accumulator
    if (ar_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = AXI_OKAY;
      case (s_axi_araddr)
        DMPWM_CTRL_OFS:   st_nxt.rdata = st_r.ctrl;
        DMPWM_STATUS_OFS: st_nxt.rdata = status_word(st_r.acc, st_r.pin, st_r.cnt);
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = AXI_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // readies registered so each bus output leaves a flop
    st_nxt.awready = !st_nxt.aw_got;
    st_nxt.wready = !st_nxt.w_got;
    st_nxt.arready = !st_nxt.rvalid;

    if (f_mode) begin
      // [R18] mode 2 ignores gating
      if (f_load) begin
        // [R17] strobe loads word
        st_nxt.duty_i = adj_duty(f_duty, f_fmt);
      end else if (f_en && tick) begin
        // [R11] accumulate step
        st_nxt.acc = acc_sum;
      end
      st_nxt.cnt = 15'h0000;
      st_nxt.extra = 4'h0;
      // [R12] carry drives pin
      m1_out = st_r.acc[10];
    end else begin
      if (f_gate && f_load) begin
        // [R09] gated load
        st_nxt.duty_i = adj_duty(f_duty, f_fmt);
        st_nxt.period_i = f_period;
      end else if (!f_gate && (st_r.cnt == max_v || !f_en)) begin
        // [R10] transfer at max
        st_nxt.duty_i = adj_duty(f_duty, f_fmt);
        st_nxt.period_i = f_period;
      end
      if (f_en && tick) begin
        // [R21] count step
        st_nxt.cnt = (st_r.cnt == max_v) ? 15'h0000 : st_r.cnt + 15'h0001;
        // [R02] set and clear
        if (at_zero) begin
          st_nxt.level = 1'b1;
        end
        if (at_cc) begin
          st_nxt.level = 1'b0;
        end
        st_nxt.extra_pend = 1'b0;
        if (at_top && dither) begin
          // [R01] dither accumulate
          st_nxt.extra = dsum[3:0];
          st_nxt.extra_pend = dsum[4];
        end
      end
      // a fresh enable starts a clean period; no stale extra pulse leaks out
      if (!f_en) begin
        st_nxt.cnt = 15'h0000;
        st_nxt.extra = 4'h0;
        st_nxt.extra_pend = 1'b0;
        st_nxt.level = 1'b0;
      end
      // [R03] [R05] [R07] extra cycle even at zero compare
      m1_out = (st_r.level && !cc_zero) || st_r.extra_pend;
      // [R09] silent without strobe
      if (f_gate && !f_load) begin
        m1_out = 1'b0;
      end
    end
    // [R14] [R15] rates follow from the word
    // [R08] [R13] enable gate, polarity
    st_nxt.pin = f_en ? (m1_out ^ f_pol) : 1'b0;

    // [R20] low power wipes control and pwm state, not the bus flops
    if (ulp_enter) begin
      st_nxt.ctrl = DMPWM_CTRL_RESET;
      st_nxt.duty_i = 10'h000;
      st_nxt.period_i = 4'h0;
      st_nxt.cnt = 15'h0000;
      st_nxt.extra = 4'h0;
      st_nxt.extra_pend = 1'b0;
      st_nxt.level = 1'b0;
      st_nxt.acc = 11'h000;
      st_nxt.pin = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // [R24] reset state
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign pwm_out       = st_r.pin;
endmodule

// File: testbench/dmpwm_properties.sv
/* checker for the pwm channel: bus answers and pin quiet states.
   assumes aw and w are offered together with all strobes set. */
`timescale 1ns/1ps
module dmpwm_properties
  import dmpwm_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ulp_enter,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pwm_out
);
  logic       en_r;
  logic [2:0] off_r;
  logic       wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // shadow enable; off count gives the pin time to settle
  always_ff @(posedge aclk) begin
    if (!aresetn || ulp_enter) begin
      en_r <= 1'b0;
    end else if (wr_go && s_axi_awaddr == DMPWM_CTRL_OFS) begin
      en_r <= s_axi_wdata[BIT_EN];
    end
    if (!aresetn || en_r) begin
      off_r <= 3'h0;
    end else if (off_r != 3'h7) begin
      off_r <= off_r + 3'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_rst_idle: assert property ($rose(aresetn) |-> !pwm_out ##1 !pwm_out)
    else $error("pin active after reset");
  chk_off_quiet: assert property (off_r == 3'h7 |-> !pwm_out)
    else $error("pin active while disabled");
  chk_ulp_quiet: assert property (ulp_enter |-> ##2 !pwm_out [*3])
    else $error("pin active after low power entry");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_wr_answer: assert property (wr_go |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3]
    |=> s_axi_rresp == AXI_SLVERR) else $error("unmapped read not refused");
  cover property (en_r && $rose(pwm_out));
  cover property (ulp_enter);
  cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule
bind dmpwm_channel dmpwm_properties chk (.*);

// File: testbench/dmpwm_load.sv
/* pin load model: counts high cycles and rising edges of the pin.
   assumes the bench clears it before each window. */
`timescale 1ns/1ps
module dmpwm_load (
  input wire logic   aclk,
  input wire logic   clr,
  input wire logic   pin,
  output logic [15:0] high_cnt,
  output logic [15:0] rise_cnt
);
  logic last_r;
  // plain resistive load, no pull: pin level is what the channel drives
  always @(posedge aclk) begin
    last_r <= pin;
    high_cnt <= clr ? 16'h0000 : high_cnt + 16'(pin);
    rise_cnt <= clr ? 16'h0000 : rise_cnt + 16'(pin && !last_r);
  end
endmodule

// File: testbench/dmpwm_channel_tb.sv
/* bench for the pwm channel: bus tasks, pin load, scenario tasks.
   assumes ce held high and the checker bound into the channel. */
`timescale 1ns/1ps
module dmpwm_channel_tb;
  import dmpwm_pkg::*;
  localparam logic [31:0] F_EN = 32'h0000_0001 << BIT_EN;
  localparam logic [31:0] F_POL = 32'h0000_0001 << BIT_POL;
  localparam logic [31:0] F_FMT = 32'h0000_0001 << BIT_FMT;
  localparam logic [31:0] F_MODE = 32'h0000_0001 << BIT_MODE;
  localparam logic [31:0] F_GL = (32'h0000_0001 << BIT_GATE) | (32'h0000_0001 << BIT_LOAD);
  logic aclk, aresetn, ce, ulp, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, pin, clr;
  logic [3:0] awa, ara, ws;
  logic [31:0] wd, rdt, d;
  logic [1:0] bs, rs, s, b;
  logic [15:0] hc, rc;
  int fail_count, samples_checked;
  dmpwm_channel DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .ulp_enter(ulp),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bs),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rs), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .pwm_out(pin));
  dmpwm_load LOAD (.aclk(aclk), .clr(clr), .pin(pin), .high_cnt(hc), .rise_cnt(rc));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic close_out;
    $display("errors %0d checks %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bad(input string m);
    fail_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_eq(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) bad(m);
  endtask
  task automatic chk_rng(input logic [15:0] g, input int lo, input int hi, input string m);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi) bad(m);
  endtask
  task automatic stall;
    bad("handshake timeout");
    close_out;
  endtask
  task automatic wr(input logic [31:0] v);
    int i;
    @(posedge aclk);
    awa <= DMPWM_CTRL_OFS; wd <= v; awv <= 1'b1; wv <= 1'b1;
    // bready follows bvalid, so the slave must hold its answer a cycle
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
      if (bv && br) begin
        b = bs;
        break;
      end
      if (bv) br <= 1'b1;
    end
    br <= 1'b0;
    if (i == 50) stall;
  endtask
  task automatic rd(input logic [3:0] a);
    int i;
    @(posedge aclk);
    ara <= a; arv <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv && rr) break;
      if (rv) rr <= 1'b1;
    end
    d = rdt; s = rs; rr <= 1'b0;
    if (i == 50) stall;
  endtask
  // window on the load: high cycles and rising edges within bounds
  task automatic meas(input int n, input int lh, input int hh, input int lr, input int hr);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (n) @(posedge aclk);
    chk_rng(hc, lh, hh, "pin high time");
    chk_rng(rc, lr, hr, "pin pulse count");
  endtask
  function automatic logic [31:0] cw(input logic [9:0] dy, input logic [3:0] pr,
      input logic [1:0] sl, input logic [31:0] f);
    return f | (32'(dy) << POS_DUTY) | (32'(pr) << POS_PERIOD) | (32'(sl) << POS_CLKSEL);
  endfunction
  task automatic t_reset;
    rd(DMPWM_CTRL_OFS);
    chk_eq(d, DMPWM_CTRL_RESET, "control after reset");
    rd(4'h8);
    chk_eq(32'(s), 32'(AXI_SLVERR), "unmapped read");
  endtask
  task automatic t_gated;
    int e;
    wr(cw(10'h300, 4'h0, 2'h0, F_FMT | F_GL));
    chk_eq(32'(b), 32'(AXI_OKAY), "write response");
    meas(500, 0, 0, 0, 0); // quiet before enable
    wr(cw(10'h300, 4'h0, 2'h0, F_FMT | F_GL | F_EN));
    rd(DMPWM_CTRL_OFS);
    chk_eq(d, cw(10'h300, 4'h0, 2'h0, F_FMT | F_GL | F_EN), "control readback");
    // four clock selects, then period one; 75 percent throughout
    for (int i = 0; i < 5; i++) begin
      e = (i < 4) ? (8 >> i) : 4;
      wr(cw(10'h300, (i < 4) ? 4'h0 : 4'h1, 2'(i % 4), F_FMT | F_GL | F_EN));
      meas(3584, 2600, 2780, e - 1, e + 1); // rate and duty
    end
    wr(cw(10'h300, 4'h0, 2'h0, F_FMT | (F_GL & ~(32'h0000_0001 << BIT_LOAD)) | F_EN));
    meas(1000, 0, 70, 0, 0); // no pulses without load
  endtask
  task automatic t_pol;
    wr(cw(10'h300, 4'h0, 2'h0, F_FMT | F_GL | F_POL | F_EN));
    meas(3584, 804, 984, 7, 9); // inverted level
  endtask
  task automatic t_mode2;
    // period set on purpose: mode 2 must ignore it; gate and load only in the strobe write
    for (int k = 0; k < 2; k++) begin
      wr(cw(10'h100, 4'h7, 2'h0, F_MODE | F_GL | (k ? F_FMT : 32'h0000_0000) | F_EN));
      wr(cw(10'h100, 4'h7, 2'h0, F_MODE | (k ? F_FMT : 32'h0000_0000) | F_EN));
      meas(3584, k ? 836 : 2628, k ? 956 : 2748, 125, 131);
    end
  endtask
  task automatic t_dither;
    wr(cw(10'h001, 4'h0, 2'h0, F_FMT)); // configure before enable
    wr(cw(10'h001, 4'h0, 2'h0, F_FMT | F_EN));
    meas(14336, 5, 24, 1, 3); // only dither pulses
  endtask
  task automatic t_ulp;
    wr(cw(10'h300, 4'h0, 2'h0, F_FMT | F_GL | F_EN));
    repeat (100) @(posedge aclk);
    ulp <= 1'b1;
    @(posedge aclk);
    ulp <= 1'b0;
    rd(DMPWM_CTRL_OFS);
    chk_eq(d, 32'h0000_0000, "control after low power");
    rd(DMPWM_STATUS_OFS);
    chk_eq(d, 32'h0000_0000, "status after low power");
    meas(2000, 0, 0, 0, 0); // pin stopped
  endtask
  initial begin
    fail_count = 0; samples_checked = 0;
    aresetn = 1'b0; ce = 1'b1; ulp = 1'b0; clr = 1'b0; ws = 4'hf;
    awa = 4'h0; awv = 1'b0; wd = 32'h0000_0000; wv = 1'b0; br = 1'b0;
    ara = 4'h0; arv = 1'b0; rr = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_gated;
    t_pol;
    t_mode2;
    t_dither;
    t_ulp;
    close_out;
  end
endmodule
